//--- common/epc_pkg.sv
// constants, command codes and carrier types of the e-paper command interpreter
// Operation
// - entry mode bits one and zero pick Y and X increment, both increment at reset
// - entry mode bit two picks the axis stepped after each memory byte
// - soft restart returns parameters to defaults, keeps memory and sleep, busy high
// - deep sleep holds busy high until rst_n or the hardware reset input is asserted
// - high voltage detection needs clock and analog on, busy high, latches result
// - cool down is 10 ms times n plus one, m loops bound the total
// - detection repeats after each cool down, stops when ready; zero is single shot
// - supply threshold codes 011 to 111 accepted, 100 at reset, others refused
// - sensor select 48h picks external sensor at reset, 80h picks internal
// - sensor write bits seven and six choose bytes sent, bits five to zero pointer
// - sensor write starts a two-wire transfer when the clock is on, busy high until it completes
// - activation runs the option stage chain with busy high throughout
// - update control nibbles pick red and black/white feed, reset 00h
// - update control second byte bit seven picks the narrower source range
// - option byte selects the activation stage chain, FFh at reset
// - black/white write stores data bytes with address advance until next command
// - red write stores data bytes in red memory with address advance
// - memory read returns bytes from the plane chosen by read option, advancing
// - status bit five is high voltage not ready, bit four supply low
// - read bytes shift out most significant bit first on falling link clock
package epc_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned COOL_MS = 10;
  localparam int unsigned COOL_CYC = CLK_HZ / 1000 * COOL_MS;
  localparam int unsigned SENSE_S = 1;
  localparam int unsigned SENSE_CYC = CLK_HZ * SENSE_S;
  localparam int unsigned VCI_US = 100;
  localparam int unsigned VCI_CYC = CLK_HZ / 1_000_000 * VCI_US;
  localparam int unsigned RESTART_US = 10;
  localparam logic [31:0] RESTART_CYC = 32'(CLK_HZ / 1_000_000 * RESTART_US);
  localparam int unsigned STAGE_US = 10;
  localparam logic [31:0] STAGE_CYC = 32'(CLK_HZ / 1_000_000 * STAGE_US);

  localparam logic [7:0] CMD_SLEEP = 8'h10;
  localparam logic [7:0] CMD_ENTRY = 8'h11;
  localparam logic [7:0] CMD_RESTART = 8'h12;
  localparam logic [7:0] CMD_HV_DET = 8'h14;
  localparam logic [7:0] CMD_VCI_DET = 8'h15;
  localparam logic [7:0] CMD_SENS_SEL = 8'h18;
  localparam logic [7:0] CMD_SENS_WR = 8'h1C;
  localparam logic [7:0] CMD_REV_RD = 8'h1F;
  localparam logic [7:0] CMD_ACTIVATE = 8'h20;
  localparam logic [7:0] CMD_UPD_CTRL = 8'h21;
  localparam logic [7:0] CMD_UPD_SEQ = 8'h22;
  localparam logic [7:0] CMD_WR_BW = 8'h24;
  localparam logic [7:0] CMD_WR_RED = 8'h26;
  localparam logic [7:0] CMD_MEM_RD = 8'h27;
  localparam logic [7:0] CMD_SENSE = 8'h28;
  localparam logic [7:0] CMD_SENSE_DUR = 8'h29;
  localparam logic [7:0] CMD_COMMON_VOLTAGE_WR = 8'h2C;
  localparam logic [7:0] CMD_STATUS_RD = 8'h2F;
  localparam logic [7:0] CMD_RD_OPT = 8'h41;
  localparam logic [7:0] CMD_X_CNT = 8'h4E;
  localparam logic [7:0] CMD_Y_CNT = 8'h4F;
  localparam logic [7:0] CMD_NOP = 8'h7F;

  localparam logic [7:0] SENS_EXT = 8'h48;
  localparam logic [7:0] SENS_INT = 8'h80;
  localparam logic [2:0] SUPPLY_MIN = 3'h3;
  localparam logic [7:0] COMMON_VOLTAGE_MIN = 8'h08;
  localparam logic [7:0] COMMON_VOLTAGE_MAX = 8'h78;
  localparam logic [1:0] CHIP_ID = 2'h1;
  // arbitrary neutral revision value
  localparam logic [7:0] REV_CODE = 8'hA5;

  localparam int unsigned X_W = 6;
  localparam int unsigned Y_W = 9;
  localparam int unsigned MEM_X_W = 4;
  localparam int unsigned MEM_AW = 1 + Y_W + MEM_X_W;

  typedef struct packed {
    logic dc;
    logic [7:0] data;
  } epc_rx_t;

  typedef struct packed {
    logic [7:0] sensor_sel;
    logic [3:0] red_mode;
    logic [3:0] bw_mode;
    logic src_narrow;
    logic [7:0] seq_opt;
    logic [7:0] common_voltage;
    logic [3:0] sense_dur;
    logic [2:0] supply_level;
    logic read_red;
    logic step_axis_sel;
    logic [1:0] step_direction;
  } epc_cfg_t;

  localparam epc_cfg_t CFG_RESET = '{sensor_sel: SENS_EXT, red_mode: 4'h0, bw_mode: 4'h0,
    src_narrow: 1'b0, seq_opt: 8'hFF, common_voltage: 8'h00, sense_dur: 4'h9,
    supply_level: 3'h4, read_red: 1'b0, step_axis_sel: 1'b0, step_direction: 2'h3};

  typedef struct packed {
    logic [1:0] count;
    logic [5:0] pointer;
    logic [7:0] par1;
    logic [7:0] par2;
  } epc_sensor_t;
endpackage

//--- hdl/epc_mem.sv
// image memory with registered read data
`timescale 1ns/100ps
module epc_mem #(
  parameter int unsigned AW = 14,
  parameter int unsigned DW = 8
) (
  // clock
  input wire logic clk,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_r
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_r <= mem[raddr];
  end
endmodule // epc_mem

//--- hdl/epc_link.sv
// serial link shifter on the host clock
`timescale 1ns/100ps
module epc_link (
  // link pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic dc,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // core side
  input wire logic clr_n,
  input wire logic [7:0] tx_byte,
  output epc_pkg::epc_rx_t rx_word,
  output logic rx_tgl
);
  import epc_pkg::*;

  logic [6:0] rx_sh;
  logic [2:0] rx_cnt;
  logic [6:0] tx_sh;
  logic [2:0] tx_cnt;

  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      rx_sh <= 7'h00;
      rx_cnt <= 3'h0;
    end else begin
      rx_sh <= {rx_sh[5:0], sda_i};
      rx_cnt <= rx_cnt + 3'h1;
    end
  end

  // word stays put until the next byte, toggle marks it
  always_ff @(posedge sck or negedge clr_n) begin
    if (!clr_n) begin
      rx_word <= '0;
      rx_tgl <= 1'b0;
    end else if (!cs_n && rx_cnt == 3'h7) begin
      rx_word <= '{dc: dc, data: {rx_sh, sda_i}};
      rx_tgl <= ~rx_tgl;
    end
  end

  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      tx_sh <= 7'h00;
      tx_cnt <= 3'h0;
    end else begin
      tx_sh <= (tx_cnt == 3'h0) ? tx_byte[6:0] : {tx_sh[5:0], 1'b0};
      tx_cnt <= tx_cnt + 3'h1;
    end
  end

  assign sda_o = (tx_cnt == 3'h0) ? tx_byte[7] : tx_sh[6];
  assign sda_oe = !cs_n && dc;
endmodule // epc_link

//--- hdl/epc_ctrl.sv
// command interpreter top: decode, busy sequencer, image memory access
`timescale 1ns/100ps
module epc_ctrl #(
  parameter int unsigned COOL_CYCLES = epc_pkg::COOL_CYC,
  parameter int unsigned SENSE_CYCLES = epc_pkg::SENSE_CYC,
  parameter int unsigned VCI_CYCLES = epc_pkg::VCI_CYC
) (
  // clock and resets
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hard_reset_n,
  // host link
  input wire logic link_sck,
  input wire logic link_cs_n,
  input wire logic link_dc,
  input wire logic link_sda_i,
  output logic link_sda_o,
  output logic link_sda_oe,
  output logic busy,
  // analog status
  input wire logic high_voltage_ok,
  input wire logic supply_input_low,
  input wire logic [7:0] common_voltage_meas,
  // sensor master
  output logic sensor_req,
  output epc_pkg::epc_sensor_t sensor_cmd,
  input wire logic sensor_done,
  // panel control
  output epc_pkg::epc_cfg_t cfg,
  output logic internal_clock_on,
  output logic analog_block_on,
  output logic stage_on,
  output logic [2:0] stage_code
);
  import epc_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_HV, ST_VCI, ST_SENSOR, ST_STAGE, ST_SENSE, ST_SLEEP} epc_state_t;

  epc_state_t state_r;
  logic hr_s1, hr_s2, hv_s1, hv_s2, sup_s1, sup_s2;
  logic t_s1, t_s2, t_s3;
  logic rst_all, link_clr_n_r;
  epc_rx_t rx_word;
  logic rx_tgl;
  logic [7:0] tx_r, mem_q, cmd_r;
  logic [1:0] par_idx_r;
  logic [X_W-1:0] x_r;
  logic [Y_W-1:0] y_r;
  logic [31:0] timer_r;
  logic [2:0] loops_r, hv_n_r, stage_idx_r;
  logic stage_last_r, hv_flag_r, vci_flag_r;
  logic ev, acc, is_cmd, is_par, mem_we, step_now, sense_end;
  logic go_sleep, go_restart, go_hv, go_vci, go_sensor, go_act, go_sense;
  logic [1:0] sens_mode;
  logic [7:0] byte_in;

  function automatic logic [X_W+Y_W-1:0] epc_step(input logic [X_W-1:0] x, input logic [Y_W-1:0] y,
                                                   input logic axis, input logic [1:0] dir);
    logic [X_W-1:0] nx;
    logic [Y_W-1:0] ny;
    nx = x;
    ny = y;
    if (axis) begin
      ny = dir[1] ? y + 1'b1 : y - 1'b1;
    end else begin
      nx = dir[0] ? x + 1'b1 : x - 1'b1;
    end
    return {nx, ny};
  endfunction

  function automatic logic sens_last(input logic [1:0] mode, input logic [1:0] idx);
    case (mode)
      2'h1: sens_last = (idx == 2'h1);
      2'h2: sens_last = (idx == 2'h2);
      default: sens_last = (idx == 2'h0);
    endcase
  endfunction

  // pin synchronisers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hr_s1 <= 1'b0;
      hr_s2 <= 1'b0;
      hv_s1 <= 1'b0;
      hv_s2 <= 1'b0;
      sup_s1 <= 1'b0;
      sup_s2 <= 1'b0;
    end else begin
      hr_s1 <= hard_reset_n;
      hr_s2 <= hr_s1;
      hv_s1 <= high_voltage_ok;
      hv_s2 <= hv_s1;
      sup_s1 <= supply_input_low;
      sup_s2 <= sup_s1;
    end
  end

  // either reset input (rst_n or the synchronised hard_reset_n) leaves sleep
  assign rst_all = !rst_n || !hr_s2;

  // link event crossing
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      link_clr_n_r <= 1'b0;
      t_s1 <= 1'b0;
      t_s2 <= 1'b0;
      t_s3 <= 1'b0;
    end else begin
      link_clr_n_r <= 1'b1;
      t_s1 <= rx_tgl;
      t_s2 <= t_s1;
      t_s3 <= t_s2;
    end
  end

  epc_link u_link (
    .sck(link_sck),
    .cs_n(link_cs_n),
    .dc(link_dc),
    .sda_i(link_sda_i),
    .sda_o(link_sda_o),
    .sda_oe(link_sda_oe),
    .clr_n(link_clr_n_r),
    .tx_byte(tx_r),
    .rx_word(rx_word),
    .rx_tgl(rx_tgl)
  );

  assign ev = t_s2 ^ t_s3;
  assign byte_in = rx_word.data;
  assign acc = (state_r == ST_IDLE);
  assign is_cmd = ev && acc && !rx_word.dc;
  assign is_par = ev && acc && rx_word.dc;
  assign sens_mode = (par_idx_r == 2'h0) ? byte_in[7:6] : sensor_cmd.count;
  assign sense_end = (state_r == ST_SENSE) && (timer_r == 32'h0);

  always_comb begin
    go_restart = is_cmd && byte_in == CMD_RESTART;
    go_act = is_cmd && byte_in == CMD_ACTIVATE;
    go_sense = is_cmd && byte_in == CMD_SENSE && internal_clock_on && analog_block_on;
    go_sleep = is_par && cmd_r == CMD_SLEEP && par_idx_r == 2'h0 && byte_in[1:0] != 2'h0;
    go_hv = is_par && cmd_r == CMD_HV_DET && par_idx_r == 2'h0 && internal_clock_on && analog_block_on;
    go_vci = is_par && cmd_r == CMD_VCI_DET && par_idx_r == 2'h0 && byte_in[2:0] >= SUPPLY_MIN
             && internal_clock_on && analog_block_on;
    go_sensor = is_par && cmd_r == CMD_SENS_WR && internal_clock_on && sens_last(sens_mode, par_idx_r);
  end

  // command tracking
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      cmd_r <= CMD_NOP;
      par_idx_r <= 2'h0;
    end else if (is_cmd) begin
      cmd_r <= byte_in;
      par_idx_r <= 2'h0;
    end else if (is_par && par_idx_r != 2'h3) begin
      par_idx_r <= par_idx_r + 2'h1;
    end
  end

  // parameter registers
  always_ff @(posedge ref_clk) begin
    if (rst_all || go_restart) begin
      cfg <= CFG_RESET;
      sensor_cmd <= '0;
    end else if (sense_end) begin
      cfg.common_voltage <= common_voltage_meas;
    end else if (is_par) begin
      case (cmd_r)
        CMD_ENTRY: begin
          cfg.step_direction <= byte_in[1:0];
          cfg.step_axis_sel <= byte_in[2];
        end
        CMD_VCI_DET: begin
          if (byte_in[2:0] >= SUPPLY_MIN) begin
            cfg.supply_level <= byte_in[2:0];
          end
        end
        CMD_SENS_SEL: begin
          if (byte_in == SENS_EXT || byte_in == SENS_INT) begin
            cfg.sensor_sel <= byte_in;
          end
        end
        CMD_SENS_WR: begin
          case (par_idx_r)
            2'h0: begin
              sensor_cmd.count <= byte_in[7:6];
              sensor_cmd.pointer <= byte_in[5:0];
            end
            2'h1: sensor_cmd.par1 <= byte_in;
            default: sensor_cmd.par2 <= byte_in;
          endcase
        end
        CMD_UPD_CTRL: begin
          if (par_idx_r == 2'h0) begin
            cfg.red_mode <= byte_in[7:4];
            cfg.bw_mode <= byte_in[3:0];
          end else if (par_idx_r == 2'h1) begin
            cfg.src_narrow <= byte_in[7];
          end
        end
        CMD_UPD_SEQ: cfg.seq_opt <= byte_in;
        CMD_SENSE_DUR: cfg.sense_dur <= byte_in[3:0];
        CMD_COMMON_VOLTAGE_WR: begin
          if (byte_in[1:0] == 2'h0 && byte_in >= COMMON_VOLTAGE_MIN && byte_in <= COMMON_VOLTAGE_MAX) begin
            cfg.common_voltage <= byte_in;
          end
        end
        CMD_RD_OPT: cfg.read_red <= byte_in[0];
        default: begin
        end
      endcase
    end
  end

  // address counters
  assign step_now = is_par && (cmd_r == CMD_WR_BW || cmd_r == CMD_WR_RED || cmd_r == CMD_MEM_RD);
  assign mem_we = is_par && (cmd_r == CMD_WR_BW || cmd_r == CMD_WR_RED);

  always_ff @(posedge ref_clk) begin
    if (rst_all || go_restart) begin
      x_r <= '0;
      y_r <= '0;
    end else if (step_now) begin
      {x_r, y_r} <= epc_step(x_r, y_r, cfg.step_axis_sel, cfg.step_direction);
    end else if (is_par && cmd_r == CMD_X_CNT && par_idx_r == 2'h0) begin
      x_r <= byte_in[X_W-1:0];
    end else if (is_par && cmd_r == CMD_Y_CNT && par_idx_r == 2'h0) begin
      y_r[7:0] <= byte_in;
    end else if (is_par && cmd_r == CMD_Y_CNT && par_idx_r == 2'h1) begin
      y_r[Y_W-1] <= byte_in[0];
    end
  end

  epc_mem #(
    .AW(MEM_AW),
    .DW(8)
  ) u_mem (
    .clk(ref_clk),
    .we(mem_we),
    .waddr({cmd_r == CMD_WR_RED, y_r, x_r[MEM_X_W-1:0]}),
    .wdata(byte_in),
    .raddr({cfg.read_red, y_r, x_r[MEM_X_W-1:0]}),
    .rdata_r(mem_q)
  );

  // read byte for the link
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      tx_r <= 8'h00;
    end else begin
      case (cmd_r)
        CMD_REV_RD: tx_r <= REV_CODE;
        CMD_STATUS_RD: tx_r <= {2'h0, hv_flag_r, vci_flag_r, 2'h0, CHIP_ID};
        CMD_MEM_RD: tx_r <= mem_q;
        default: tx_r <= 8'h00;
      endcase
    end
  end

  // busy sequencer
  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      state_r <= ST_IDLE;
      timer_r <= 32'h0;
      loops_r <= 3'h0;
      hv_n_r <= 3'h0;
      stage_idx_r <= 3'h0;
      stage_last_r <= 1'b0;
      hv_flag_r <= 1'b0;
      vci_flag_r <= 1'b0;
      sensor_req <= 1'b0;
      internal_clock_on <= 1'b0;
      analog_block_on <= 1'b0;
      stage_on <= 1'b0;
      stage_code <= 3'h0;
    end else begin
      sensor_req <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (go_sleep) begin
            state_r <= ST_SLEEP;
          end else if (go_restart) begin
            hv_flag_r <= 1'b0;
            vci_flag_r <= 1'b0;
            timer_r <= RESTART_CYC - 32'h1;
            state_r <= ST_WAIT;
          end else if (go_hv) begin
            hv_n_r <= byte_in[6:4];
            loops_r <= byte_in[2:0];
            timer_r <= (byte_in[2:0] == 3'h0) ? 32'h0 : 32'(COOL_CYCLES * (byte_in[6:4] + 1)) - 32'h1;
            state_r <= ST_HV;
          end else if (go_vci) begin
            timer_r <= 32'(VCI_CYCLES) - 32'h1;
            state_r <= ST_VCI;
          end else if (go_sensor) begin
            sensor_req <= 1'b1;
            state_r <= ST_SENSOR;
          end else if (go_act) begin
            stage_idx_r <= 3'h7;
            stage_last_r <= 1'b0;
            timer_r <= 32'h0;
            state_r <= ST_STAGE;
          end else if (go_sense) begin
            timer_r <= 32'(SENSE_CYCLES * (cfg.sense_dur + 1)) - 32'h1;
            state_r <= ST_SENSE;
          end
        end
        ST_WAIT: begin
          if (timer_r != 32'h0) begin
            timer_r <= timer_r - 32'h1;
          end else begin
            state_r <= ST_IDLE;
          end
        end
        ST_HV: begin
          if (timer_r != 32'h0) begin
            timer_r <= timer_r - 32'h1;
          end else if (hv_s2) begin
            hv_flag_r <= 1'b0;
            state_r <= ST_IDLE;
          end else if (loops_r <= 3'h1) begin
            hv_flag_r <= 1'b1;
            state_r <= ST_IDLE;
          end else begin
            loops_r <= loops_r - 3'h1;
            timer_r <= 32'(COOL_CYCLES * (hv_n_r + 1)) - 32'h1;
          end
        end
        ST_VCI: begin
          if (timer_r != 32'h0) begin
            timer_r <= timer_r - 32'h1;
          end else begin
            vci_flag_r <= sup_s2;
            state_r <= ST_IDLE;
          end
        end
        ST_SENSOR: begin
          if (sensor_done) begin
            state_r <= ST_IDLE;
          end
        end
        ST_STAGE: begin
          // walk option bits high to low
          if (timer_r != 32'h0) begin
            timer_r <= timer_r - 32'h1;
          end else if (stage_last_r) begin
            stage_on <= 1'b0;
            state_r <= ST_IDLE;
          end else begin
            stage_on <= cfg.seq_opt[stage_idx_r];
            stage_code <= stage_idx_r;
            if (cfg.seq_opt[stage_idx_r]) begin
              timer_r <= STAGE_CYC - 32'h1;
              case (stage_idx_r)
                3'h7: internal_clock_on <= 1'b1;
                3'h6: analog_block_on <= 1'b1;
                3'h1: analog_block_on <= 1'b0;
                3'h0: internal_clock_on <= 1'b0;
                default: begin
                end
              endcase
            end
            stage_last_r <= (stage_idx_r == 3'h0);
            stage_idx_r <= stage_idx_r - 3'h1;
          end
        end
        ST_SENSE: begin
          if (timer_r != 32'h0) begin
            timer_r <= timer_r - 32'h1;
          end else begin
            state_r <= ST_IDLE;
          end
        end
        ST_SLEEP: state_r <= ST_SLEEP;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  assign busy = (state_r != ST_IDLE);
endmodule // epc_ctrl

//--- verif/epc_chk_properties.sv
// port assertions of the command interpreter
`timescale 1ns/100ps
module epc_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // link
  input wire logic link_cs_n,
  input wire logic link_dc,
  input wire logic link_sda_oe,
  // status and control
  input wire logic busy,
  input wire logic sensor_req,
  input wire logic sensor_done,
  input wire epc_pkg::epc_cfg_t cfg,
  input wire logic internal_clock_on,
  input wire logic stage_on
);
  import epc_pkg::*;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  property p_reset_dflt;
    $rose(rst_n) |-> cfg == CFG_RESET && !busy;
  endproperty
  a_reset_dflt: assert property (p_reset_dflt)
    else $error("defaults missing after reset");
  property p_req_pulse;
    sensor_req |=> !sensor_req;
  endproperty
  a_req_pulse: assert property (p_req_pulse)
    else $error("sensor start longer than one cycle");
  property p_req_busy;
    sensor_req |=> busy[*3];
  endproperty
  a_req_busy: assert property (p_req_busy)
    else $error("busy low during sensor transfer");
  property p_done_end;
    busy && sensor_done |-> ##[1:3] !busy;
  endproperty
  a_done_end: assert property (p_done_end)
    else $error("busy stuck after sensor done");
  property p_stage_busy;
    stage_on |-> busy;
  endproperty
  a_stage_busy: assert property (p_stage_busy)
    else $error("stage runs without busy");
  property p_sda_dir;
    link_sda_oe == (!link_cs_n && link_dc);
  endproperty
  a_sda_dir: assert property (p_sda_dir)
    else $error("data pin direction wrong");
  property p_clk_hold;
    !busy |=> $stable(internal_clock_on);
  endproperty
  a_clk_hold: assert property (p_clk_hold)
    else $error("clock enable moved while idle");
  property p_busy_req;
    busy && $past(busy) && $past(busy, 2) |-> !sensor_req;
  endproperty
  a_busy_req: assert property (p_busy_req)
    else $error("sensor start while busy");
endmodule // epc_chk

bind epc_ctrl epc_chk i_chk (.ref_clk(ref_clk), .rst_n(rst_n), .link_cs_n(link_cs_n), .link_dc(link_dc),
  .link_sda_oe(link_sda_oe), .busy(busy), .sensor_req(sensor_req), .sensor_done(sensor_done), .cfg(cfg),
  .internal_clock_on(internal_clock_on), .stage_on(stage_on));

//--- verif/epc_host.sv
// host model on the serial command link
`timescale 1ns/100ps
module epc_host (
  // link pins
  output logic sck,
  output logic cs_n,
  output logic dc,
  output logic sda_i,
  input wire logic sda_o
);
  logic hb = 1'b1;
  logic rdg = 1'b0;
  // select low then high at start so the link shifters clear before the first frame
  initial begin
    sck = 1'b0;
    cs_n = 1'b0;
    dc = 1'b0;
    #1 cs_n = 1'b1;
  end
  assign sda_i = rdg ? sda_o : hb;
  // msb first, taken on rising sck
  task automatic xfer(input logic d, input logic rm, input logic [7:0] b, output logic [7:0] r);
    #200 cs_n = 1'b0;
    dc = d;
    rdg = rm;
    for (int i = 7; i >= 0; i--) begin
      hb = b[i];
      #24 sck = 1'b1;
      r[i] = sda_i;
      #24 sck = 1'b0;
    end
    #30 cs_n = 1'b1;
    rdg = 1'b0;
    hb = ~hb;
  endtask
endmodule // epc_host

//--- verif/tb_epc_ctrl.sv
// self-checking bench of the command interpreter
`timescale 1ns/100ps
module tb_epc_ctrl;
  import epc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hrst_n = 1'b1;
  logic hv_ok = 1'b0;
  logic vlow = 1'b0;
  logic done = 1'b0;
  logic sck, cs_n, dc, sda_i, sda_o, busy, req, clk_on, an_on;
  logic st_on;
  logic [2:0] st_code;
  epc_sensor_t scmd;
  epc_sensor_t got;
  epc_cfg_t cfg;
  logic [7:0] r;
  int n_errors = 0;
  int check_count = 0;
  int n;
  epc_ctrl #(.COOL_CYCLES(20), .SENSE_CYCLES(30), .VCI_CYCLES(10)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .hard_reset_n(hrst_n), .link_sck(sck), .link_cs_n(cs_n), .link_dc(dc), .link_sda_i(sda_i),
    .link_sda_o(sda_o), .link_sda_oe(), .busy(busy), .high_voltage_ok(hv_ok), .supply_input_low(vlow),
    .common_voltage_meas(8'h3C), .sensor_req(req), .sensor_cmd(scmd), .sensor_done(done), .cfg(cfg),
    .internal_clock_on(clk_on), .analog_block_on(an_on), .stage_on(st_on), .stage_code(st_code));
  epc_host i_host (.sck(sck), .cs_n(cs_n), .dc(dc), .sda_i(sda_i), .sda_o(sda_o));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // sensor side answers a few cycles after each start
  always @(posedge ref_clk) begin
    if (req === 1'b1) begin
      got <= scmd;
      repeat (4) @(posedge ref_clk);
      done <= 1'b1;
      @(posedge ref_clk);
      done <= 1'b0;
    end
  end
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", s, exp, seen);
    end
  endtask
  task automatic c(input logic [7:0] b);
    i_host.xfer(1'b0, 1'b0, b, r);
  endtask
  task automatic p(input logic [7:0] b);
    i_host.xfer(1'b1, 1'b0, b, r);
  endtask
  task automatic rc(input string s, input logic [7:0] e);
    i_host.xfer(1'b1, 1'b1, 8'h00, r);
    chk(s, r, e);
  endtask
  // wait for busy low, n counts it
  task automatic idle();
    n = 0;
    repeat (8) @(posedge ref_clk);
    while (busy !== 1'b0 && n < 9000) begin
      @(posedge ref_clk);
      n++;
    end
    chk("busy_end", busy, 1'b0);
  endtask
  task automatic cp(input logic [7:0] a, input logic [7:0] b);
    c(a);
    p(b);
    idle();
  endtask
  task automatic xy(input logic [7:0] x);
    cp(8'h4E, x);
    cp(8'h4F, 8'h00);
    p(8'h00);
  endtask
  initial begin
    #300_000;
    n_errors++;
    test_done();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("por", cfg, CFG_RESET);
    cp(8'h11, 8'h05);
    chk("entry", {cfg.step_axis_sel, cfg.step_direction}, 3'h5);
    cp(8'h18, 8'h80);
    cp(8'h18, 8'h33);
    chk("sens", cfg.sensor_sel, 8'h80);
    cp(8'h21, 8'h48);
    p(8'h80);
    idle();
    chk("upd", {cfg.red_mode, cfg.bw_mode, cfg.src_narrow}, 9'h091);
    cp(8'h2C, 8'h0A);
    chk("vc_bad", cfg.common_voltage, 8'h00);
    cp(8'h2C, 8'h78);
    chk("vc", cfg.common_voltage, 8'h78);
    cp(8'h29, 8'h03);
    chk("sdur", cfg.sense_dur, 4'h3);
    cp(8'h11, 8'h07);
    xy(8'h00);
    c(8'h24);
    p(8'h3C);
    p(8'hC3);
    cp(8'h11, 8'h03);
    xy(8'h01);
    cp(8'h24, 8'h96);
    xy(8'h00);
    c(8'h27);
    rc("rx0", 8'h3C);
    rc("rx1", 8'h96);
    cp(8'h11, 8'h07);
    xy(8'h00);
    c(8'h27);
    rc("ry1", 8'h3C);
    rc("ry2", 8'hC3);
    cp(8'h11, 8'h02);
    xy(8'h01);
    c(8'h27);
    rc("xdec1", 8'h96);
    rc("xdec0", 8'h3C);
    xy(8'h00);
    cp(8'h26, 8'h5A);
    cp(8'h41, 8'h01);
    xy(8'h00);
    c(8'h27);
    rc("red", 8'h5A);
    c(8'h12);
    repeat (8) @(posedge ref_clk);
    chk("rs_busy", busy, 1'b1);
    idle();
    chk("rs_cfg", cfg, CFG_RESET);
    c(8'h27);
    rc("keep", 8'h3C);
    c(8'h2F);
    rc("stat0", 8'h01);
    c(8'h1F);
    rc("rev", REV_CODE);
    cp(8'h22, 8'hC0);
    c(8'h20);
    repeat (8) @(posedge ref_clk);
    chk("act", busy, 1'b1);
    chk("stage", {st_on, st_code}, 4'hF);
    idle();
    chk("on", {clk_on, an_on}, 2'h3);
    c(8'h28);
    idle();
    chk("sense_t", n > 280 && n < 300, 1'b1);
    chk("sense_v", cfg.common_voltage, 8'h3C);
    cp(8'h14, 8'h12);
    chk("hv_t", n > 60 && n < 90, 1'b1);
    c(8'h2F);
    rc("hv_nr", 8'h21);
    hv_ok <= 1'b1;
    cp(8'h14, 8'h77);
    chk("hv_stop", n < 200, 1'b1);
    cp(8'h14, 8'h00);
    vlow <= 1'b1;
    cp(8'h15, 8'h02);
    chk("lvl_bad", cfg.supply_level, 3'h4);
    cp(8'h15, 8'h07);
    chk("lvl", cfg.supply_level, 3'h7);
    c(8'h2F);
    rc("st1", 8'h11);
    c(8'h1C);
    p(8'h8A);
    p(8'h11);
    p(8'h22);
    idle();
    chk("scmd", got, 24'h8A1122);
    c(8'h10);
    p(8'h01);
    c(8'h11);
    p(8'h00);
    repeat (8) @(posedge ref_clk);
    chk("sleep", {busy, cfg.step_direction}, 3'h7);
    hrst_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    hrst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("wake", busy, 1'b0);
    test_done();
  end
endmodule // tb_epc_ctrl
